// *** rtl/fdt_pkg.sv ***
package fdt_pkg;

  // APB geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets, one aligned word each
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_ARM_KEY   = 8'h04;
  localparam logic [7:0] OFF_CLEAR_KEY = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_CNT_LOW   = 8'h10;
  localparam logic [7:0] OFF_CNT_HIGH  = 8'h14;
  localparam logic [7:0] OFF_MATCH_LOW = 8'h18;
  localparam logic [7:0] OFF_MATCH_HIGH = 8'h1c;
  localparam logic [7:0] OFF_WIN_LOW   = 8'h20;
  localparam logic [7:0] OFF_WIN_HIGH  = 8'h24;

  // Field positions
  localparam int CTRL_ON_BIT       = 15;
  localparam int ARM_KEY_LSB       = 8;
  localparam int CLEAR_KEY_LSB     = 0;
  localparam int STAT_ARM_ERR_BIT  = 7;
  localparam int STAT_CLR_ERR_BIT  = 6;
  localparam int STAT_EVENT_BIT    = 5;
  localparam int STAT_WIN_OPEN_BIT = 0;

  // Key codes
  localparam logic [7:0] ARM_CODE   = 8'h40;
  localparam logic [7:0] CLEAR_CODE = 8'h08;

  // Reset values
  localparam logic [7:0]  KEY_RESET   = 8'h00;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] DATA_RESET  = 32'h0000_0000;

  // One register access as the core logic sees it
  typedef struct packed {
    logic              wr;     // Write completes this edge
    logic [ADDR_W-1:0] addr;   // Byte address
    logic [DATA_W-1:0] wdata;  // Write data
  } fdt_access_t;

  // Fuse configuration bundle
  typedef struct packed {
    logic        enable;  // Fuse enable
    logic [31:0] match;   // Count match value
    logic [31:0] window;  // Clear window interval
  } fdt_fuse_t;

endpackage : fdt_pkg

// *** rtl/fdt_apb_slave.sv ***
`timescale 1ns/1ps

module fdt_apb_slave
(
  input  wire logic                      clock_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [fdt_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [fdt_pkg::DATA_W-1:0] pwdata_i,
  input  wire logic [fdt_pkg::DATA_W-1:0] rdata_i,
  input  wire logic                      hit_i,
  output logic                           pready_o,
  output logic [fdt_pkg::DATA_W-1:0]     prdata_o,
  output logic                           pslverr_o,
  output fdt_pkg::fdt_access_t           access_o
);

  ////////////////////////////////////////////////////////////////////
  // One wait state: answer is registered, so read data is stable

  typedef struct packed {
    logic                      ready;  // Access phase ends
    logic [fdt_pkg::DATA_W-1:0] rdata;  // Captured read data
    logic                      err;    // Unmapped address
  } fdt_slave_state_t;

  fdt_slave_state_t state;       // Registered state
  fdt_slave_state_t next_state;  // Next state

  // Build answer on the first access cycle, drop it after
  always_comb
  begin
    next_state = state;
    if (psel_i && penable_i && !state.ready)
    begin
      next_state.ready = 1'b1;
      next_state.rdata = pwrite_i ? fdt_pkg::DATA_RESET : rdata_i;
      next_state.err   = !hit_i;
    end
    else
    begin
      next_state.ready = 1'b0;
      next_state.err   = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= '0;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////
  // Writes land only at the edge where pready is sampled high

  assign access_o.wr    = psel_i && penable_i && pwrite_i &&
                          state.ready && hit_i;
  assign access_o.addr  = paddr_i;
  assign access_o.wdata = pwdata_i;
  assign pready_o       = state.ready;
  assign prdata_o       = state.rdata;
  assign pslverr_o      = state.err;

endmodule : fdt_apb_slave

// *** rtl/fdt_deadman.sv ***
`timescale 1ns/1ps

module fdt_deadman
(
  input  wire logic                       clock_i,
  input  wire logic                       reset_n_i,
  // APB slave port
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [fdt_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [fdt_pkg::DATA_W-1:0] pwdata_i,
  output logic                            pready_o,
  output logic [fdt_pkg::DATA_W-1:0]      prdata_o,
  output logic                            pslverr_o,
  // Processor side, same clock
  input  wire logic                       fetch_pulse_i,
  // Fuse configuration, static after power-up
  input  wire logic                       fuse_timer_enable_i,
  input  wire logic [31:0]                fuse_match_i,
  input  wire logic [31:0]                fuse_window_i,
  // Results
  output logic                            reset_request_o,
  output logic                            clear_window_open_o
);

  ////////////////////////////////////////////////////////////////////
  // Types and state

  // One packed struct carries every flop of this module, so the
  // reset branch and the update live in one process each and no
  // field can be left out of the update.
  // The counter dominates the area; keys and flags are a few bits.
  // The software enable sits here too, since it is a plain flop.
  //
  // Everything this module remembers
  typedef struct packed {
    logic        sw_on;           // Software enable bit
    logic [7:0]  arm_key;         // Arm key field
    logic [7:0]  clear_key;       // Clear key field
    logic        arm_key_error;   // Bad arm write seen
    logic        clear_key_error; // Bad clear write seen
    logic        timeout_event;   // Timeout event flag
    logic        window_open;     // Clear window open
    logic [31:0] count;           // Fetch counter
    logic        reset_request;   // Request to reset logic
  } fdt_state_t;

  fdt_state_t state;       // Registered state
  fdt_state_t next_state;  // Next state

  fdt_pkg::fdt_access_t acc;    // Completed access from the bus
  fdt_pkg::fdt_fuse_t   fuse;   // Fuse bundle
  logic [31:0]          rdata;  // Read mux result
  logic                 hit;    // Address is mapped
  logic                 run;    // Timer is enabled

  ////////////////////////////////////////////////////////////////////
  // Bus slave

  // The slave answers with one wait state. Registering the answer
  // costs a cycle per access but keeps prdata_o and pready_o
  // straight from flops, with no path from the address to a pin.
  // Writes land only at the completing edge, so a master that
  // stalls in the access phase cannot write twice.
  //
  // Handshake lives in its own module; it only returns strobes
  fdt_apb_slave u_slave
  (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .rdata_i   (rdata),
    .hit_i     (hit),
    .pready_o  (pready_o),
    .prdata_o  (prdata_o),
    .pslverr_o (pslverr_o),
    .access_o  (acc)
  );

  // Limitation: the fuse values are taken as static after power-up.
  // A change while counting moves the match and window points at
  // once, and the mirrors follow the live inputs, not a snapshot.
  // Fuse logic runs on this clock, so no synchroniser is needed.
  //
  // Fuses come from logic on this clock, no synchroniser needed
  assign fuse.enable = fuse_timer_enable_i;
  assign fuse.match  = fuse_match_i;
  assign fuse.window = fuse_window_i;

  ////////////////////////////////////////////////////////////////////
  // Enable selection

  // A plain OR is enough: with the fuse enable set the software
  // bit cannot stop the timer, and with it clear the software bit
  // alone decides. Software can therefore never switch off a timer
  // that the fuses turned on.
  //
  // Fuse enable overrides; software bit only matters without it
  assign run = fuse.enable || state.sw_on;

  ////////////////////////////////////////////////////////////////////
  // Read decode

  // Decode runs on the raw address in the setup and access phases;
  // the slave captures the word on the first access cycle.
  // Hazard: the counter halves are read in two transfers with no
  // hold latch, so a carry between the two reads can make the pair
  // look torn. Software that needs both halves should read high,
  // low, then high again and retry if the high half moved.
  // Traded for a smaller block with no extra register.
  //
  // Every mapped word; unused bits fall out as zero
  always_comb
  begin
    rdata = fdt_pkg::DATA_RESET;
    hit   = 1'b1;
    case (paddr_i)
      fdt_pkg::OFF_CONTROL:
      begin
        // Control: only the enable bit exists
        rdata[fdt_pkg::CTRL_ON_BIT] = state.sw_on;
      end
      fdt_pkg::OFF_ARM_KEY:
      begin
        // Arm key sits in the upper byte
        rdata[fdt_pkg::ARM_KEY_LSB +: 8] = state.arm_key;
      end
      fdt_pkg::OFF_CLEAR_KEY:
      begin
        // Clear key in the low byte, upper byte zero
        rdata[fdt_pkg::CLEAR_KEY_LSB +: 8] = state.clear_key;
      end
      fdt_pkg::OFF_STATUS:
      begin
        // Flags only; bits 15:8 and 4:1 stay zero
        rdata[fdt_pkg::STAT_ARM_ERR_BIT] =
          state.arm_key_error;
        rdata[fdt_pkg::STAT_CLR_ERR_BIT] =
          state.clear_key_error;
        rdata[fdt_pkg::STAT_EVENT_BIT] =
          state.timeout_event;
        rdata[fdt_pkg::STAT_WIN_OPEN_BIT] =
          state.window_open;
      end
      fdt_pkg::OFF_CNT_LOW:
      begin
        // Live counter, low half
        rdata[15:0] = state.count[15:0];
      end
      fdt_pkg::OFF_CNT_HIGH:
      begin
        // Live counter, high half
        rdata[15:0] = state.count[31:16];
      end
      fdt_pkg::OFF_MATCH_LOW:
      begin
        // Mirror of the fuse match, low half
        rdata[15:0] = fuse.match[15:0];
      end
      fdt_pkg::OFF_MATCH_HIGH:
      begin
        // Mirror of the fuse match, high half
        rdata[15:0] = fuse.match[31:16];
      end
      fdt_pkg::OFF_WIN_LOW:
      begin
        // Mirror of the fuse window, low half
        rdata[15:0] = fuse.window[15:0];
      end
      fdt_pkg::OFF_WIN_HIGH:
      begin
        // Mirror of the fuse window, high half
        rdata[15:0] = fuse.window[31:16];
      end
      default:
      begin
        // Unmapped: zero data and an error answer
        hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Priority, lowest first:
  //   counting, then the match check on the new count,
  //   then software writes, which may restart the count,
  //   then the window and the request, both from the final values.
  // A valid clear therefore beats a fetch in the same cycle, and
  // the window drops on the very edge that the clear lands.
  // Bad key writes raise the event even with the timer off; a
  // stray write from runaway code is exactly what must be caught.
  // The clear is not gated by the window, so software may restart
  // the count at any time with the right two-step sequence.
  // The flags have no clear path here at all; only reset ends them.
  //
  // Key writes, counting and flags in one place so priority is clear
  always_comb
  begin
    next_state = state;

    // Counting: one step per fetch, stopping at the match value.
    // A sleeping core sends no fetch pulses, so time freezes too.
    if (run && fetch_pulse_i && (state.count != fuse.match))
    begin
      next_state.count = state.count + 32'h0000_0001;
    end

    // Counter reaching the match value is a timeout
    if (run && (next_state.count == fuse.match))
    begin
      next_state.timeout_event = 1'b1;
    end

    // Software writes
    if (acc.wr)
    begin
      case (acc.addr)
        fdt_pkg::OFF_CONTROL:
        begin
          // Software enable bit
          next_state.sw_on = acc.wdata[fdt_pkg::CTRL_ON_BIT];
        end
        fdt_pkg::OFF_ARM_KEY:
        begin
          // Any value is stored; only the arm code is good
          next_state.arm_key =
            acc.wdata[fdt_pkg::ARM_KEY_LSB +: 8];
          if (acc.wdata[fdt_pkg::ARM_KEY_LSB +: 8] != fdt_pkg::ARM_CODE)
          begin
            // Bad arm value: flag it, counts as a timeout too
            next_state.arm_key_error = 1'b1;
            next_state.timeout_event = 1'b1;
          end
        end
        fdt_pkg::OFF_CLEAR_KEY:
        begin
          if ((acc.wdata[fdt_pkg::CLEAR_KEY_LSB +: 8] ==
               fdt_pkg::CLEAR_CODE) &&
              (state.arm_key == fdt_pkg::ARM_CODE))
          begin
            // Good sequence: restart; clear beats a same-cycle fetch
            next_state.arm_key   = fdt_pkg::KEY_RESET;
            next_state.clear_key = fdt_pkg::KEY_RESET;
            next_state.count     = fdt_pkg::COUNT_RESET;
          end
          else
          begin
            // Wrong pattern or out of order: keep arm, take value
            next_state.clear_key =
              acc.wdata[fdt_pkg::CLEAR_KEY_LSB +: 8];
            next_state.clear_key_error = 1'b1;
            next_state.timeout_event   = 1'b1;
          end
        end
        default:
        begin
          // Status, counter and mirrors ignore writes
          next_state.sw_on = state.sw_on;
        end
      endcase
    end

    // Window tracks the counter, so it drops as soon as it restarts
    next_state.window_open =
      (next_state.count >= fuse.window);

    // Reset request follows the event flag; the flag only clears
    // when the reset it caused comes back around
    next_state.reset_request = next_state.timeout_event;
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  // The reset branch assigns constants only, so the asynchronous
  // path never depends on other flops or on the bus.
  // Reset is expected from the processor reset logic, which this
  // block itself asks for; the loop closes outside this module.
  //
  // The timer reset event is the module reset; it empties keys
  // and flags, and nothing else can clear the flags
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state.sw_on           <= 1'b0;
      state.arm_key         <= fdt_pkg::KEY_RESET;
      state.clear_key       <= fdt_pkg::KEY_RESET;
      state.arm_key_error   <= 1'b0;
      state.clear_key_error <= 1'b0;
      state.timeout_event   <= 1'b0;
      state.window_open     <= 1'b0;
      state.count           <= fdt_pkg::COUNT_RESET;
      state.reset_request   <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Both results are levels: the request stays high until reset,
  // so the reset logic may sample it at its own pace.
  // Outputs, straight from flip-flops

  assign reset_request_o     = state.reset_request;
  assign clear_window_open_o = state.window_open;

endmodule : fdt_deadman

// *** verification/fdt_deadman_monitor.sv ***
`timescale 1ns/1ps

module fdt_deadman_monitor
(
  input wire logic                       clock_i,
  input wire logic                       reset_n_i,
  input wire logic                       psel_i,
  input wire logic                       penable_i,
  input wire logic                       pwrite_i,
  input wire logic [fdt_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [fdt_pkg::DATA_W-1:0] pwdata_i,
  input wire logic                       pready_o,
  input wire logic [fdt_pkg::DATA_W-1:0] prdata_o,
  input wire logic                       pslverr_o,
  input wire logic                       fetch_pulse_i,
  input wire logic [31:0]                fuse_match_i,
  input wire logic [31:0]                fuse_window_i,
  input wire logic                       reset_request_o,
  input wire logic                       clear_window_open_o
);
  // Transfer completes, any direction or write only
  wire done    = psel_i && penable_i && pready_o;
  wire wr_done = done && pwrite_i;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // First access cycle, still waiting for the answer
  sequence s_access_start;
    psel_i && penable_i && !pready_o;
  endsequence
  // Read of a mirror returns the fuse half in bits 15:0
  property p_mirror(logic [7:0] off, logic [15:0] val);
    done && !pwrite_i && paddr_i == off |-> prdata_o == {16'h0000, val};
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_ready_wait: assert property (s_access_start |=> pready_o)
    else $error("answer not one cycle after the first access cycle");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held for more than one cycle");
  a_unmapped_err: assert property (done && paddr_i > fdt_pkg::OFF_WIN_HIGH
    |-> pslverr_o && prdata_o == '0) else $error("unmapped access accepted");
  a_match_low: assert property (p_mirror(fdt_pkg::OFF_MATCH_LOW,
    fuse_match_i[15:0])) else $error("match mirror low wrong");
  a_match_high: assert property (
    p_mirror(fdt_pkg::OFF_MATCH_HIGH, fuse_match_i[31:16]))
    else $error("match mirror high wrong");
  a_window_low: assert property (p_mirror(fdt_pkg::OFF_WIN_LOW,
    fuse_window_i[15:0])) else $error("window mirror low wrong");
  a_window_high: assert property (p_mirror(fdt_pkg::OFF_WIN_HIGH,
    fuse_window_i[31:16])) else $error("window mirror high wrong");
  a_status_layout: assert property (done && !pwrite_i
    && paddr_i == fdt_pkg::OFF_STATUS |-> prdata_o[31:8] == '0
    && prdata_o[4:1] == '0 && prdata_o[5] == $past(reset_request_o)
    && prdata_o[0] == $past(clear_window_open_o))
    else $error("status word layout wrong");
  a_bad_clear: assert property (wr_done
    && paddr_i == fdt_pkg::OFF_CLEAR_KEY
    && pwdata_i[7:0] != fdt_pkg::CLEAR_CODE |=> reset_request_o)
    else $error("bad clear key raised no request");
  a_bad_arm: assert property (wr_done
    && paddr_i == fdt_pkg::OFF_ARM_KEY
    && pwdata_i[15:8] != fdt_pkg::ARM_CODE |=> reset_request_o)
    else $error("bad arm key raised no request");
  a_request_hold: assert property (
    reset_request_o |=> reset_request_o)
    else $error("reset request dropped without reset");
  a_window_rise: assert property ($rose(clear_window_open_o)
    |-> $past(fetch_pulse_i) || fuse_window_i == 32'h0000_0000)
    else $error("window opened without a fetch");
  a_window_fall: assert property ($fell(clear_window_open_o)
    |-> $past(wr_done && paddr_i == fdt_pkg::OFF_CLEAR_KEY
    && pwdata_i[7:0] == fdt_pkg::CLEAR_CODE))
    else $error("window closed without a clear");
endmodule : fdt_deadman_monitor

bind fdt_deadman fdt_deadman_monitor i_fdt_deadman_monitor (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .fetch_pulse_i(fetch_pulse_i),
  .fuse_match_i(fuse_match_i), .fuse_window_i(fuse_window_i),
  .reset_request_o(reset_request_o),
  .clear_window_open_o(clear_window_open_o));

// *** verification/fdt_core_model.sv ***
`timescale 1ns/1ps

// Processor stand-in: one fetch a cycle, or one in three when slow
module fdt_core_model
(
  input  wire logic   clock_i,
  input  wire logic   reset_n_i,
  input  wire logic   awake_i,       // Low models sleep
  input  wire logic   slow_i,        // Sparse fetches
  input  wire logic   reset_req_i,   // Reset request from the timer
  output logic        fetch_pulse_o,
  output logic [31:0] fetch_count_o  // Fetches issued since reset
);
  logic [1:0] phase;  // Slow-mode divider
  // Counter sees the same edges as the timer, so counts agree while the timer runs and is below the match value
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      phase <= 2'h0;
      fetch_pulse_o <= 1'b0;
      fetch_count_o <= 32'h0;
    end
    else
    begin
      phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      // No fetch asleep or held in reset
      fetch_pulse_o <= awake_i && !reset_req_i && (!slow_i || phase == 2'h0);
      fetch_count_o <= fetch_count_o + {31'h0, fetch_pulse_o};
    end
  end
endmodule : fdt_core_model

// *** verification/fetch_deadman_clear_status_bench.sv ***
`timescale 1ns/1ps

module fetch_deadman_clear_status_bench;
  logic clock_i = 1'b0, reset_n_i = 1'b0, awake = 1'b0, slow = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, fetch, reset_req, win_open;
  logic [7:0]  paddr = 8'h00, bad;
  logic [31:0] pwdata = 32'h0, prdata, fetches;
  logic [33:0] note, exp_q[$];  // Read flag, error flag, data
  fdt_pkg::fdt_fuse_t fuse = '0;
  int num_errors = 0, checks_done = 0, seed = 83;
  fdt_deadman i_fdt_deadman (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .fetch_pulse_i(fetch),
    .fuse_timer_enable_i(fuse.enable), .fuse_match_i(fuse.match),
    .fuse_window_i(fuse.window), .reset_request_o(reset_req),
    .clear_window_open_o(win_open));
  fdt_core_model i_fdt_core_model (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .awake_i(awake), .slow_i(slow), .reset_req_i(reset_req),
    .fetch_pulse_o(fetch), .fetch_count_o(fetches));
  initial
    forever #50 clock_i = ~clock_i;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input string what, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk_word
  task automatic chk_bit(input string what, input logic e, g);
    chk_word(what, {31'h0, e}, {31'h0, g});
  endtask : chk_bit
  // Watcher retires the oldest note at each completed transfer
  always @(posedge clock_i)
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      chk_bit("pslverr", note[32], pslverr);
      if (note[33])
        chk_word("prdata", note[31:0], prdata);
    end
  // One APB transfer; read data expected is noted, not compared here
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic err = 1'b0);
    int n = 0;
    exp_q.push_back({!wr, err, wr ? 32'h0 : d});
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge clock_i);
    penable <= 1'b1;
    do
      @(posedge clock_i);
    while (pready !== 1'b1 && ++n < 16);
    if (pready !== 1'b1)
      num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Let the core fetch for a while, then put it to sleep
  task automatic run(input logic s, input int cycles);
    awake <= 1'b1;
    slow <= s;
    repeat (cycles) @(posedge clock_i);
    awake <= 1'b0;
    repeat (3) @(posedge clock_i);
  endtask : run
  task automatic do_reset(input fdt_pkg::fdt_fuse_t f);
    reset_n_i <= 1'b0;
    fuse <= f;
    repeat (16) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
  endtask : do_reset
  task automatic give_verdict();
    $display("Checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // Timer off, random fuses: mirrors, read-only status, unmapped
    do_reset('{1'b0, $random(seed), $random(seed) | 32'h1});
    run(1'b0, 8);
    apb(1'b0, fdt_pkg::OFF_CNT_LOW, 32'h0);
    apb(1'b0, fdt_pkg::OFF_MATCH_LOW, fuse.match & 32'hffff);
    apb(1'b0, fdt_pkg::OFF_MATCH_HIGH, fuse.match >> 16);
    apb(1'b0, fdt_pkg::OFF_WIN_LOW, fuse.window & 32'hffff);
    apb(1'b0, fdt_pkg::OFF_WIN_HIGH, fuse.window >> 16);
    apb(1'b1, fdt_pkg::OFF_STATUS, 32'hffff_ffff);
    apb(1'b0, fdt_pkg::OFF_STATUS, 32'h0);
    apb(1'b0, 8'h28, 32'h0, 1'b1);
    apb(1'b1, 8'h28, 32'hffff_ffff, 1'b1);
    // Software enable, count through the window up to the match
    do_reset('{1'b0, 32'd50, 32'd20});
    apb(1'b1, fdt_pkg::OFF_CONTROL, 32'h0000_8000);
    apb(1'b0, fdt_pkg::OFF_CONTROL, 32'h0000_8000);
    run(1'b0, 12);
    apb(1'b0, fdt_pkg::OFF_CNT_LOW, fetches);
    apb(1'b0, fdt_pkg::OFF_STATUS, 32'h0);
    run(1'b1, 30);
    chk_bit("window", fetches >= 20, win_open);
    run(1'b0, 40);
    apb(1'b0, fdt_pkg::OFF_CNT_LOW, 32'd50);
    chk_bit("request", 1'b1, reset_req);
    apb(1'b0, fdt_pkg::OFF_STATUS, 32'h21);
    // Bad clear after arm, then a proper sequence, then a bad arm
    bad = 8'($random(seed));
    if (bad == fdt_pkg::CLEAR_CODE)
      bad = 8'h09;
    apb(1'b1, fdt_pkg::OFF_ARM_KEY, 32'h0000_4000);
    apb(1'b1, fdt_pkg::OFF_CLEAR_KEY, {16'h0, 8'hff, bad});
    apb(1'b0, fdt_pkg::OFF_ARM_KEY, 32'h0000_4000);
    apb(1'b0, fdt_pkg::OFF_CLEAR_KEY, {24'h0, bad});
    apb(1'b0, fdt_pkg::OFF_STATUS, 32'h61);
    apb(1'b1, fdt_pkg::OFF_ARM_KEY, 32'h0000_4000);
    apb(1'b1, fdt_pkg::OFF_CLEAR_KEY, 32'h0000_0008);
    apb(1'b0, fdt_pkg::OFF_CNT_LOW, 32'h0);
    apb(1'b0, fdt_pkg::OFF_ARM_KEY, 32'h0);
    apb(1'b0, fdt_pkg::OFF_CLEAR_KEY, 32'h0);
    chk_bit("window", 1'b0, win_open);
    apb(1'b1, fdt_pkg::OFF_ARM_KEY, 32'h0000_1200);
    apb(1'b0, fdt_pkg::OFF_STATUS, 32'he0);
    // Fuse enable alone; counter carries into the high half
    do_reset('{1'b1, 32'h0001_0004, 32'hffff_ffff});
    apb(1'b0, fdt_pkg::OFF_CLEAR_KEY, 32'h0);
    apb(1'b0, fdt_pkg::OFF_ARM_KEY, 32'h0);
    run(1'b0, 65545);
    apb(1'b0, fdt_pkg::OFF_CNT_HIGH, 32'h1);
    apb(1'b0, fdt_pkg::OFF_CNT_LOW, 32'h4);
    give_verdict();
  end
  // Watchdog: the whole run needs about 66k cycles
  initial
  begin
    repeat (90000) @(posedge clock_i);
    num_errors++;
    give_verdict();
  end
endmodule : fetch_deadman_clear_status_bench
